/* File: logic/vfs_pkg.sv */
// constants shared by the field and line timing block
package vfs_pkg;
    localparam int CLK_PERIOD_NS     = 100;
    localparam int CNT_W             = 12;
    // back porch gate length
    localparam int BP_TIME_US        = 4;
    // gap that counts as a full line, shorter gaps are half-line gaps
    localparam int LINE_GAP_TIME_NS  = 45000;
    // sync low this long means a broad vertical pulse
    localparam int BROAD_TIME_NS     = 20000;
    // fallback delay from the start of vertical sync
    localparam int DEFAULT_TIME_NS   = 50000;
    // vertical output pulse length
    localparam int VPULSE_TIME_NS    = 180000;

    localparam logic [CNT_W-1:0] BP_CYC       =
        CNT_W'((BP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] LINE_GAP_CYC =
        CNT_W'((LINE_GAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] BROAD_CYC    =
        CNT_W'((BROAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] DEFAULT_CYC  =
        CNT_W'((DEFAULT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] DEFAULT_LAST = DEFAULT_CYC - CNT_W'(1);
    localparam logic [CNT_W-1:0] VPULSE_CYC   =
        CNT_W'((VPULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] CNT_ZERO     = '0;
    localparam logic [CNT_W-1:0] CNT_ONE      = CNT_W'(1);

    typedef enum logic {
        VFS_LEVEL_LOW,
        VFS_LEVEL_HIGH
    } vfs_level_t;
endpackage

/* File: logic/vfs_timer_if.sv */
// start and output of one pulse timer
`timescale 1ns/1ps
`default_nettype none
interface vfs_timer_if;
    logic start;
    logic level;
    logic busy;
    modport ctrl  (output start, input level, input busy);
    modport timer (input start, output level, output busy);
endinterface
`default_nettype wire

/* File: logic/vfs_timer.sv */
// retriggerable fixed-length pulse timer
`timescale 1ns/1ps
`default_nettype none
module vfs_timer
    import vfs_pkg::*;
#(
    parameter int               W         = CNT_W,
    parameter logic [W-1:0]     COUNT     = W'(1),
    parameter vfs_level_t       ACT_LEVEL = VFS_LEVEL_HIGH
) (
    // clock and control
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       clkEn,
    // start and pulse
    vfs_timer_if.timer      tif
);
    localparam logic [W-1:0] LAST   = COUNT - W'(1);
    localparam logic [W-1:0] ZERO   = '0;
    localparam logic         ACTIVE = (ACT_LEVEL == VFS_LEVEL_HIGH);

    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    logic         next_busy;

    always_comb begin
        next_cnt  = cnt;
        next_busy = tif.busy;
        if (tif.start) begin
            // a new start restarts the full length
            next_cnt  = LAST;
            next_busy = 1'b1;
        end else if (tif.busy) begin
            if (cnt == ZERO) begin
                next_busy = 1'b0;
            end else begin
                next_cnt = cnt - W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cnt       <= '0;
            tif.busy  <= 1'b0;
            tif.level <= ~ACTIVE;
        end else if (clkEn) begin
            cnt       <= next_cnt;
            tif.busy  <= next_busy;
            tif.level <= next_busy ? ACTIVE : ~ACTIVE;
        end
    end

    a_timer_start: assert property (@(posedge clk) disable iff (reset)
        clkEn && tif.start |=> tif.level == ACTIVE)
        else $error("timer did not start its pulse");
endmodule
`default_nettype wire

/* File: logic/vfs_selector.sv */
// field index, vertical pulse and back porch gate from composite sync
`timescale 1ns/1ps
`default_nettype none
// Operation
// - field index low even, high odd
// - long gap clears parity, equalizing toggles
// - odd half line toggles; sample at vertical
// - field starts at first or second equalizer
// - sync trailing edge starts 4 us gate
// - vertical pulse starts at first serration
// - default vertical pulse after delay expires
module vfs_selector
    import vfs_pkg::*;
(
    // clock and control
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic clkEn,
    // composite sync, low during sync tips
    input  wire logic syncIn_n,
    // timing marks
    output var  logic fieldIndex,
    output var  logic vertPulse,
    output var  logic backPorch_n
);
    // ****************************************
    // edges of the sync stream
    // ****************************************
    logic syncPrev;
    logic lead;
    logic trail;

    assign lead  = syncPrev & ~syncIn_n;
    assign trail = ~syncPrev & syncIn_n;

    // ****************************************
    // gap and pulse length measurement
    // ****************************************
    logic [CNT_W-1:0] gapCnt;
    logic [CNT_W-1:0] lowCnt;
    logic [CNT_W-1:0] next_gapCnt;
    logic [CNT_W-1:0] next_lowCnt;
    logic             gapFull;

    // counters saturate so a stopped sync stream cannot wrap them
    assign gapFull = (gapCnt == LINE_GAP_CYC);

    always_comb begin
        next_gapCnt = gapCnt;
        next_lowCnt = lowCnt;
        if (lead) begin
            next_gapCnt = CNT_ZERO;
            next_lowCnt = CNT_ZERO;
        end else if (syncIn_n) begin
            if (!gapFull) begin
                next_gapCnt = gapCnt + CNT_ONE;
            end
        end else if (lowCnt != DEFAULT_CYC) begin
            next_lowCnt = lowCnt + CNT_ONE;
        end
    end

    // ****************************************
    // parity flip-flop
    // ****************************************
    logic parity;
    logic next_parity;

    always_comb begin
        next_parity = parity;
        if (syncIn_n && gapFull) begin
            next_parity = 1'b0;
        end else if (lead) begin
            // half-line gaps, the odd field's last half line among them
            next_parity = ~parity;
        end
    end

    // ****************************************
    // vertical pulse start
    // ****************************************
    logic armed;
    logic next_armed;
    logic serrStart;
    logic defaultHit;
    logic vertStart;

    assign serrStart  = armed & trail;
    assign defaultHit = armed & ~syncIn_n & (lowCnt == DEFAULT_LAST);
    assign vertStart  = serrStart | defaultHit;

    always_comb begin
        next_armed = armed;
        if (vertStart || gapFull) begin
            next_armed = 1'b0;
        end else if (!syncIn_n && lowCnt == BROAD_CYC && !vertPulse) begin
            // broad pulse seen, wait for its serration edge
            next_armed = 1'b1;
        end
    end

    // ****************************************
    // field index
    // ****************************************
    logic next_fieldIndex;

    // sampled only at the vertical start, so it holds a whole field
    always_comb begin
        next_fieldIndex = fieldIndex;
        if (vertStart) begin
            next_fieldIndex = parity;
        end
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            syncPrev   <= 1'b1;
            gapCnt     <= '0;
            lowCnt     <= '0;
            parity     <= 1'b0;
            armed      <= 1'b0;
            fieldIndex <= 1'b0;
        end else if (clkEn) begin
            syncPrev   <= syncIn_n;
            gapCnt     <= next_gapCnt;
            lowCnt     <= next_lowCnt;
            parity     <= next_parity;
            armed      <= next_armed;
            fieldIndex <= next_fieldIndex;
        end
    end

    // ****************************************
    // pulse timers
    // ****************************************
    vfs_timer_if bpIf ();
    vfs_timer_if vpIf ();

    assign bpIf.start  = trail;
    assign vpIf.start  = vertStart;
    assign backPorch_n = bpIf.level;
    assign vertPulse   = vpIf.level;

    vfs_timer #(
        .W         (CNT_W),
        .COUNT     (BP_CYC),
        .ACT_LEVEL (VFS_LEVEL_LOW)
    ) bpTimer (
        .clk   (clk),
        .reset (reset),
        .clkEn (clkEn),
        .tif   (bpIf)
    );

    vfs_timer #(
        .W         (CNT_W),
        .COUNT     (VPULSE_CYC),
        .ACT_LEVEL (VFS_LEVEL_HIGH)
    ) vpTimer (
        .clk   (clk),
        .reset (reset),
        .clkEn (clkEn),
        .tif   (vpIf)
    );

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // consecutive enabled cycles the gate has been low
    logic [CNT_W-1:0] bpLowCnt;

    always_ff @(posedge clk) begin
        if (reset) begin
            bpLowCnt <= '0;
        end else if (clkEn) begin
            bpLowCnt <= (!backPorch_n && !trail) ? bpLowCnt + CNT_ONE : CNT_ZERO;
        end
    end

    sequence armedSerration;
        clkEn && armed && trail;
    endsequence

    sequence armedTimeout;
        clkEn && armed && !syncIn_n && lowCnt == DEFAULT_LAST;
    endsequence

    a_bp_start: assert property (
        clkEn && trail |=> !backPorch_n)
        else $error("back porch gate not asserted after sync trailing edge");

    // the count reaches the full length on the sample that sees the release edge
    a_bp_length: assert property (
        bpLowCnt <= BP_CYC)
        else $error("back porch gate held longer than its length");

    a_bp_release: assert property (
        bpLowCnt == BP_CYC |-> backPorch_n)
        else $error("back porch gate not released after its length");

    a_parity_clear: assert property (
        clkEn && syncIn_n && gapFull |=> !parity)
        else $error("parity not cleared after a full line gap");

    a_parity_toggle: assert property (
        clkEn && lead && !gapFull |=> parity != $past(parity))
        else $error("parity did not toggle on a half-line pulse");

    a_field_sample: assert property (
        clkEn && vertStart |=> fieldIndex == $past(parity))
        else $error("field index not sampled from parity at vertical start");

    a_field_hold: assert property (
        !(clkEn && vertStart) |=> $stable(fieldIndex))
        else $error("field index changed inside a field");

    a_vert_serration: assert property (
        armedSerration |=> vertPulse ##1 vertPulse)
        else $error("vertical pulse missing after first serration");

    a_vert_default: assert property (
        armedTimeout |=> vertPulse)
        else $error("default vertical pulse missing after delay");
endmodule
`default_nettype wire

/* File: bench/vfs_sync_src.sv */
// composite sync source and downstream line selector models around the timing block
`timescale 1ns/1ps
`default_nettype none
module vfs_sync_src (
    // clock
    input  wire logic clk,
    // composite sync, low during sync tips
    output var  logic syncIn_n
);
    // ****************
    // level sequencing
    // ****************
    initial syncIn_n = 1'b1;

    // levels move just after the falling edge, clear of the sampling edge
    task automatic hold(input logic lvl, input int n);
        syncIn_n = lvl;
        repeat (n) @(negedge clk);
    endtask

    // full line: the long gap lets the parity clear
    task automatic fullLine();
        hold(1'b0, 47);
        hold(1'b1, 593);
    endtask

    task automatic equalizer();
        hold(1'b0, 23);
        hold(1'b1, 297);
    endtask

    // an odd field ends on a half line, which acts like an equalizing gap
    task automatic fieldEnd(input logic odd);
        repeat (3) fullLine();
        if (odd) begin
            hold(1'b0, 47);
            hold(1'b1, 273);
        end
        repeat (6) equalizer();
    endtask

    // rest of the vertical interval after the first serration rises
    task automatic vertRest();
        hold(1'b1, 47);
        repeat (5) begin
            hold(1'b0, 272);
            hold(1'b1, 48);
        end
        repeat (6) equalizer();
        repeat (3) fullLine();
    endtask
endmodule

// downstream line selector: counts sync transitions after each load
module vfs_line_sel #(
    parameter int   STAGES   = 2,
    parameter int   LINES    = 1,
    parameter logic ODD_ONLY = 1'b0
) (
    // clock and control
    input  wire logic       clk,
    input  wire logic       reset,
    // composite sync and the timing marks from the block
    input  wire logic       syncIn_n,
    input  wire logic       vertPulse,
    input  wire logic       fieldIndex,
    input  wire logic       backPorch_n,
    // desired line plus two
    input  wire logic [7:0] lineSelectWord,
    // video path
    input  wire logic [7:0] videoIn,
    output var  logic       videoPass,
    output var  logic       countOn,
    output var  logic [7:0] videoOut
);
    // ****************
    // counter and gate
    // ****************
    // each 4-bit stage extends the reach of the target line
    localparam int CW = 4 * STAGES;

    logic [CW-1:0] downCnt;
    logic [7:0]    passLeft;
    logic [7:0]    blackLvl;
    logic          syncPrev;
    logic          loadPrev;
    logic          loadSig;
    logic          step;

    // the rise of our active-high pulse is the start of the vertical pulse;
    // the rise of the index is the fall of its inverse, which picks the odd field
    assign loadSig   = ODD_ONLY ? fieldIndex : vertPulse;
    assign step      = countOn && (syncIn_n != syncPrev);
    assign videoPass = countOn && (downCnt == '0);
    assign videoOut  = videoPass ? videoIn : blackLvl;

    always_ff @(posedge clk) begin
        if (reset) begin
            downCnt  <= '0;
            passLeft <= 8'h00;
            blackLvl <= 8'h00;
            syncPrev <= 1'b1;
            loadPrev <= 1'b0;
            countOn  <= 1'b0;
        end else begin
            syncPrev <= syncIn_n;
            loadPrev <= loadSig;
            if (!backPorch_n) begin
                blackLvl <= videoIn;
            end
            if (loadSig && !loadPrev) begin
                downCnt  <= CW'(lineSelectWord);
                passLeft <= 8'(2 * LINES);
                countOn  <= 1'b1;
            end else if (step) begin
                if (downCnt != '0) begin
                    downCnt <= downCnt - 1'b1;
                end else if (passLeft > 8'h01) begin
                    passLeft <= passLeft - 8'h01;
                end else begin
                    // gate falls here and stops all counting until the next load
                    countOn <= 1'b0;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
// self-checking bench for the field index, vertical pulse and back porch gate
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import vfs_pkg::*;

    logic      clk;
    logic      reset;
    logic      clkEn;
    wire logic syncIn_n;
    logic      fieldIndex;
    logic      vertPulse;
    logic      backPorch_n;
    int        miscompares;
    int        n_checks;
    logic [7:0] videoLvl;
    logic       linePass;
    logic       lineCount;
    logic [7:0] lineVideo;
    logic       oddPass;
    logic       oddCount;

    // target line 14, given as line plus two
    localparam logic [7:0] LINE_WORD = 8'h10;

    vfs_selector i_vfs_selector (
        .clk         (clk),
        .reset       (reset),
        .clkEn       (clkEn),
        .syncIn_n    (syncIn_n),
        .fieldIndex  (fieldIndex),
        .vertPulse   (vertPulse),
        .backPorch_n (backPorch_n)
    );

    vfs_sync_src i_vfs_sync_src (
        .clk      (clk),
        .syncIn_n (syncIn_n)
    );

    vfs_line_sel #(
        .STAGES   (2),
        .LINES    (1),
        .ODD_ONLY (1'b0)
    ) i_vfs_line_sel (
        .clk            (clk),
        .reset          (reset),
        .syncIn_n       (syncIn_n),
        .vertPulse      (vertPulse),
        .fieldIndex     (fieldIndex),
        .backPorch_n    (backPorch_n),
        .lineSelectWord (LINE_WORD),
        .videoIn        (videoLvl),
        .videoPass      (linePass),
        .countOn        (lineCount),
        .videoOut       (lineVideo)
    );

    // odd field only, two adjacent lines
    vfs_line_sel #(
        .STAGES   (2),
        .LINES    (2),
        .ODD_ONLY (1'b1)
    ) i_vfs_line_sel_odd (
        .clk            (clk),
        .reset          (reset),
        .syncIn_n       (syncIn_n),
        .vertPulse      (vertPulse),
        .fieldIndex     (fieldIndex),
        .backPorch_n    (backPorch_n),
        .lineSelectWord (LINE_WORD),
        .videoIn        (videoLvl),
        .videoPass      (oddPass),
        .countOn        (oddCount),
        .videoOut       ()
    );

    // ******************
    // checking and pacing
    // ******************
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        if (miscompares == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    // **********
    // scenarios
    // **********
    // gate length counts enabled cycles only, so a frozen stretch lengthens it
    task automatic backPorchGate();
        check("count idle", lineCount, 1'b0);
        check("pass idle", linePass, 1'b0);
        check("odd count idle", oddCount, 1'b0);
        i_vfs_sync_src.hold(1'b0, 10);
        check("gate before", backPorch_n, 1'b1);
        // the gate drops at the edge that sees the trailing edge
        i_vfs_sync_src.hold(1'b1, 1);
        check("gate low", backPorch_n, 1'b0);
        tick(10);
        clkEn = 1'b0;
        tick(20);
        clkEn = 1'b1;
        tick(29);
        check("gate held", backPorch_n, 1'b0);
        tick(1);
        check("gate released", backPorch_n, 1'b1);
        videoLvl = 8'hc3;
        tick(1);
        check("black level", lineVideo, 8'h3c);
    endtask

    // odd selects the field that starts; the odd field follows one ending on a full line, the even one a half line
    task automatic fieldMark(input logic odd);
        i_vfs_sync_src.fieldEnd(!odd);
        i_vfs_sync_src.hold(1'b0, 272);
        check("vert early", vertPulse, 1'b0);
        i_vfs_sync_src.hold(1'b1, 1);
        fork
            i_vfs_sync_src.vertRest();
            begin
                check("vert start", vertPulse, 1'b1);
                check("field index", fieldIndex, odd);
                tick(1799);
                check("vert held", vertPulse, 1'b1);
                check("field kept", fieldIndex, odd);
                tick(1);
                check("vert end", vertPulse, 1'b0);
                tick(510);
                check("line early", linePass, 1'b0);
                check("odd early", oddPass, 1'b0);
                tick(1);
                check("line 14 open", linePass, 1'b1);
                check("odd open", oddPass, odd);
                tick(319);
                check("line held", linePass, 1'b1);
                check("odd held", oddPass, odd);
                tick(1);
                check("line closed", linePass, 1'b0);
                check("count stopped", lineCount, 1'b0);
                check("odd second line", oddPass, odd);
                tick(319);
                check("odd last", oddPass, odd);
                tick(1);
                check("odd closed", oddPass, 1'b0);
                check("odd count stopped", oddCount, 1'b0);
            end
        join
    endtask

    // broad sync with no serration must still yield a pulse, but not early
    task automatic defaultStart();
        int k;
        k = 0;
        i_vfs_sync_src.hold(1'b0, 480);
        check("no default yet", vertPulse, 1'b0);
        while (vertPulse !== 1'b1 && k < 100) begin
            i_vfs_sync_src.hold(1'b0, 1);
            k++;
        end
        if (k == 100) begin
            miscompares++;
            summarize();
        end else begin
            check("default pulse", vertPulse, 1'b1);
            i_vfs_sync_src.hold(1'b1, 2000);
            check("default ended", vertPulse, 1'b0);
        end
    endtask

    // ****
    // run
    // ****
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        reset = 1'b1;
        clkEn = 1'b1;
        videoLvl = 8'h3c;
        miscompares = 0;
        n_checks = 0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        backPorchGate();
        fieldMark(1'b0);
        fieldMark(1'b1);
        defaultStart();
        summarize();
    end
endmodule
`default_nettype wire
